// *** src/uifc_dma.sv ***
/*
 * dma request and single-request generator for both directions.
 * assumes fifo levels and settings arrive on the same clock.
 */
`timescale 1ns/1ns
module uifc_dma
	import uifc_pkg::*;
#(
	parameter int DEPTH = 16
) (
	input wire logic clk, // system clock
	input wire logic rst_b, // async reset, active low
	uifc_lvl_if.dma lv, // levels and settings
	output logic tx_req_n, // tx dma request, active low
	output logic tx_single_n, // tx single request, active low
	output logic rx_req_n, // rx dma request, active low
	output logic rx_single_n // rx single request, active low
);
	typedef struct packed {
		logic tx_req_n;
		logic tx_single_n;
		logic rx_req_n;
		logic rx_single_n;
	} uifc_dma_st_t;

	uifc_dma_st_t st_reg;
	uifc_dma_st_t st_next;
	logic tx_full;
	logic rx_empty;

	assign tx_full = int'(lv.tx_level) == DEPTH;
	assign rx_empty = lv.rx_level == '0;

	// request conditions per mode, kept active low so outputs leave flops directly
	always_comb begin
		st_next = st_reg;
		st_next.tx_single_n = tx_full;
		st_next.rx_single_n = rx_empty;
		if (lv.dma_mode == UIFC_DMA_SINGLE || !lv.fifo_en) begin
			st_next.tx_req_n = lv.tx_level != '0;
			st_next.rx_req_n = rx_empty;
		end else begin
			if (lv.tx_level <= lv.tx_thr_lvl) begin
				st_next.tx_req_n = 1'b0;
			end else if (tx_full) begin
				st_next.tx_req_n = 1'b1;
			end
			if (lv.rx_level >= lv.rx_trig_lvl || lv.rx_timeout) begin
				st_next.rx_req_n = 1'b0;
			end else if (rx_empty) begin
				st_next.rx_req_n = 1'b1;
			end
		end
		if (lv.rx_rst) begin
			st_next.rx_req_n = 1'b1;
			st_next.rx_single_n = 1'b1;
		end
		if (lv.tx_rst) begin
			st_next.tx_req_n = 1'b1;
			st_next.tx_single_n = 1'b1;
		end
	end

	// reset leaves every request deasserted
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= '1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign tx_req_n = st_reg.tx_req_n;
	assign tx_single_n = st_reg.tx_single_n;
	assign rx_req_n = st_reg.rx_req_n;
	assign rx_single_n = st_reg.rx_single_n;
endmodule

// *** src/uifc_lvl_if.sv ***
/*
 * carrier between the control block and its dma request generator.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
interface uifc_lvl_if #(parameter int LW = 5) ();
	logic [LW-1:0] rx_level;
	logic [LW-1:0] tx_level;
	logic [LW-1:0] rx_trig_lvl;
	logic [LW-1:0] tx_thr_lvl;
	logic fifo_en;
	logic dma_mode;
	logic rx_rst;
	logic tx_rst;
	logic rx_timeout;
	modport ctl (output rx_level, tx_level, rx_trig_lvl, tx_thr_lvl, fifo_en, dma_mode,
		rx_rst, tx_rst, rx_timeout);
	modport dma (input rx_level, tx_level, rx_trig_lvl, tx_thr_lvl, fifo_en, dma_mode,
		rx_rst, tx_rst, rx_timeout);
endinterface

// *** src/uifc_pkg.sv ***
/*
 * constants shared by the interrupt identification / fifo control block:
 * register address, field positions, reset values and identification codes.
 * assumes nothing of its surroundings.
 */
package uifc_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [31:0] UIFC_INT_IDENT_FIFO_CTRL_ADDR = 32'hb0002008;
	localparam logic [7:0] UIFC_IDENT_RESET = 8'h01;
	localparam logic [1:0] UIFC_CTRL2_RESET = 2'h0;
	localparam logic UIFC_CTRL1_RESET = 1'h0;

	// ------------------------------------------------------------
	// write-side field positions
	// ------------------------------------------------------------
	localparam int UIFC_FIFO_EN_POS = 0;
	localparam int UIFC_RX_RST_POS = 1;
	localparam int UIFC_TX_RST_POS = 2;
	localparam int UIFC_DMA_MODE_POS = 3;
	localparam int UIFC_TX_THR_LSB = 4;
	localparam int UIFC_RX_TRIG_LSB = 6;

	// ------------------------------------------------------------
	// read-side field positions and interrupt-enable bits
	// ------------------------------------------------------------
	localparam int UIFC_CODE_LSB = 0;
	localparam int UIFC_FIFOSTAT_LSB = 6;
	localparam int UIFC_IEN_RX_DATA = 0;
	localparam int UIFC_IEN_TX_EMPTY = 1;
	localparam int UIFC_IEN_LINE = 2;
	localparam int UIFC_IEN_MODEM = 3;
	localparam int UIFC_IEN_PROG_EMPTY = 7;

	// ------------------------------------------------------------
	// pending interrupt codes
	// ------------------------------------------------------------
	localparam logic [3:0] UIFC_CODE_MODEM = 4'h0;
	localparam logic [3:0] UIFC_CODE_NONE = 4'h1;
	localparam logic [3:0] UIFC_CODE_HOLD_EMPTY = 4'h2;
	localparam logic [3:0] UIFC_CODE_RX_DATA = 4'h4;
	localparam logic [3:0] UIFC_CODE_LINE = 4'h6;
	localparam logic [3:0] UIFC_CODE_BUSY = 4'h7;
	localparam logic [3:0] UIFC_CODE_TIMEOUT = 4'hc;
	localparam logic [1:0] UIFC_FIFOSTAT_ON = 2'h3;
	localparam logic [1:0] UIFC_FIFOSTAT_OFF = 2'h0;

	// ------------------------------------------------------------
	// dma signalling modes
	// ------------------------------------------------------------
	localparam logic UIFC_DMA_SINGLE = 1'b0;
	localparam logic UIFC_DMA_MULTI = 1'b1;

endpackage

// *** src/uifc_prio.sv ***
/*
 * priority encoder for pending interrupt sources.
 * assumes every source is already gated by its enable and is a level.
 */
`timescale 1ns/1ns
module uifc_prio
	import uifc_pkg::*;
(
	input wire logic line_pend, // receiver line status
	input wire logic rx_pend, // received data available
	input wire logic tmo_pend, // character timeout
	input wire logic hold_pend, // holding register empty
	input wire logic modem_pend, // modem status
	output logic [3:0] code // highest pending code
);
	// fixed order; the busy code is never produced
	always_comb begin
		if (line_pend) begin
			code = UIFC_CODE_LINE;
		end else if (rx_pend) begin
			code = UIFC_CODE_RX_DATA;
		end else if (tmo_pend) begin
			code = UIFC_CODE_TIMEOUT;
		end else if (hold_pend) begin
			code = UIFC_CODE_HOLD_EMPTY;
		end else if (modem_pend) begin
			code = UIFC_CODE_MODEM;
		end else begin
			code = UIFC_CODE_NONE;
		end
	end
endmodule

// *** src/uifc_top.sv ***
/*
 * interrupt identification / fifo control of a serial port.
 * one address: reads give the identification view, writes the control view.
 * assumes the fifos, line status, modem status and interrupt-enable logic
 * sit beside it on the same clock and hand over their state as levels.
 */
// What this block does
// - reads show identification, writes change control
// - codes modem 0000, none 0001, empty 0010
// - codes rx data 0100, line 0110, timeout 1100
// - busy code 0111 never reported
// - identification bits 4 and 5 read zero
// - bits 6-7 read 11 enabled, 00 disabled
// - reset reads 0x01; upper 24 bits zero
// - bit 0 enables fifos; change resets both
// - bit 1 resets rx fifo, drops rx dma
// - bit 2 resets tx fifo, drops tx dma
// - both fifo reset bits clear themselves
// - bits 4-5 pick tx empty threshold
// - tx threshold steers tx dma request
// - bits 6-7 pick rx trigger level
// - auto flow control drops rts at trigger
// - rx trigger steers rx dma request
// - enable bit 1 and programmable mode bit 7
// - enable bit 0 gates rx data interrupt
`timescale 1ns/1ns
module uifc_top
	import uifc_pkg::*;
#(
	parameter int DEPTH = 16,
	parameter int LW = $clog2(DEPTH + 1)
) (
	input wire logic clk, // system clock, 25 mhz
	input wire logic rst_b, // async reset, active low
	input wire logic [31:0] addr, // register byte address
	input wire logic wr_en, // write strobe
	input wire logic rd_en, // read strobe
	input wire logic [31:0] wdata, // write data
	output logic [31:0] rdata, // read data, one cycle after rd_en
	input wire logic [7:0] int_enable, // interrupt-enable register
	input wire logic afce, // auto flow control enable
	input wire logic rts_request, // software rts request
	input wire logic line_status_pend, // receiver line status event
	input wire logic modem_status_pend, // modem status event
	input wire logic char_timeout, // character timeout event
	input wire logic thr_written, // holding register written
	input wire logic [LW-1:0] rx_level, // rx fifo fill level
	input wire logic [LW-1:0] tx_level, // tx fifo fill level
	output logic fifo_enable, // fifos enabled
	output logic rx_fifo_reset, // rx fifo control reset pulse
	output logic tx_fifo_reset, // tx fifo control reset pulse
	output logic rts_n, // request to send, active low
	output logic intr, // any enabled interrupt pending
	output logic dma_tx_req_n, // tx dma request, active low
	output logic dma_tx_single_n, // tx single request, active low
	output logic dma_rx_req_n, // rx dma request, active low
	output logic dma_rx_single_n // rx single request, active low
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic fifo_enable_bit;
		logic dma_mode_select;
		logic [1:0] tx_empty_threshold;
		logic [1:0] rx_trigger_level;
		logic rx_fifo_reset_bit;
		logic tx_fifo_reset_bit;
		logic [7:0] rdata;
		logic holding_empty_event;
		logic hold_cond_d;
		logic rts_n;
		logic intr;
	} uifc_top_st_t;

	uifc_top_st_t st_reg;
	uifc_top_st_t st_next;

	uifc_lvl_if #(.LW(LW)) lv ();

	logic wr_hit;
	logic rd_hit;
	logic rx_data_irq_enable;
	logic tx_empty_irq_enable;
	logic programmable_empty_irq_mode;
	logic [LW-1:0] tx_thr_lvl;
	logic [LW-1:0] rx_trig_lvl;
	logic hold_cond;
	logic rx_avail;
	logic [3:0] pending_interrupt_code;
	logic [1:0] fifos_enabled_status;
	logic [7:0] interrupt_ident_view;
	logic [7:0] fifo_control_view;
	logic line_gated;
	logic rx_gated;
	logic tmo_gated;
	logic modem_gated;
	logic hold_armed;
	logic hold_rise;
	logic hold_clear;
	logic wr_fifo_en;
	logic wr_rx_rst;
	logic wr_tx_rst;
	logic wr_enable_flip;
	logic rts_flow_stop;
	logic [7:0] rd_value;

	// ------------------------------------------------------------
	// threshold decoders
	// ------------------------------------------------------------

	// tx empty threshold in characters
	function automatic logic [LW-1:0] tx_thr_decode(input logic [1:0] sel);
		logic [LW-1:0] v;
		v = '0;
		unique case (sel)
			2'h0: v = '0;
			2'h1: v = LW'(2);
			2'h2: v = LW'(DEPTH / 4);
			2'h3: v = LW'(DEPTH / 2);
		endcase
		return v;
	endfunction

	// rx trigger level in characters
	function automatic logic [LW-1:0] rx_trig_decode(input logic [1:0] sel);
		logic [LW-1:0] v;
		v = '0;
		unique case (sel)
			2'h0: v = LW'(1);
			2'h1: v = LW'(DEPTH / 4);
			2'h2: v = LW'(DEPTH / 2);
			2'h3: v = LW'(DEPTH - 2);
		endcase
		return v;
	endfunction

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------

	// the same address answers both directions
	assign wr_hit = wr_en && (addr == UIFC_INT_IDENT_FIFO_CTRL_ADDR);
	assign rd_hit = rd_en && (addr == UIFC_INT_IDENT_FIFO_CTRL_ADDR);

	// ------------------------------------------------------------
	// control writes
	// ------------------------------------------------------------

	// fields of the written byte
	assign wr_fifo_en = wdata[UIFC_FIFO_EN_POS];
	assign wr_rx_rst = wdata[UIFC_RX_RST_POS];
	assign wr_tx_rst = wdata[UIFC_TX_RST_POS];

	// any change of the enable resets both fifos
	assign wr_enable_flip = wr_hit && (wr_fifo_en != fifo_control_view[UIFC_FIFO_EN_POS]);

	// ------------------------------------------------------------
	// interrupt enables
	// ------------------------------------------------------------
	assign rx_data_irq_enable = int_enable[UIFC_IEN_RX_DATA];
	assign tx_empty_irq_enable = int_enable[UIFC_IEN_TX_EMPTY];
	assign programmable_empty_irq_mode = int_enable[UIFC_IEN_PROG_EMPTY]
		&& st_reg.fifo_enable_bit;

	// ------------------------------------------------------------
	// fill-level conditions
	// ------------------------------------------------------------

	// thresholds follow the control view; with fifos off only one slot counts
	assign tx_thr_lvl = tx_thr_decode(st_reg.tx_empty_threshold);
	assign rx_trig_lvl = st_reg.fifo_enable_bit ?
		rx_trig_decode(st_reg.rx_trigger_level) : LW'(1);

	// holding empty: at or below threshold in programmable mode, else empty
	assign hold_cond = programmable_empty_irq_mode ?
		(tx_level <= tx_thr_lvl) : (tx_level == '0);

	// received data reaches the selected trigger level
	assign rx_avail = rx_level >= rx_trig_lvl;

	// flow control holds rts off from the trigger level on
	assign rts_flow_stop = afce && st_reg.fifo_enable_bit && rx_avail;

	// ------------------------------------------------------------
	// interrupt sources
	// ------------------------------------------------------------

	// each source counts only while its enable bit is set
	assign line_gated = line_status_pend && int_enable[UIFC_IEN_LINE];
	assign rx_gated = rx_avail && rx_data_irq_enable;
	assign tmo_gated = char_timeout && rx_data_irq_enable;
	assign modem_gated = modem_status_pend && int_enable[UIFC_IEN_MODEM];

	// holding empty is edge-armed so a steady empty fifo raises it once
	assign hold_armed = hold_cond && tx_empty_irq_enable;
	assign hold_rise = hold_armed && !st_reg.hold_cond_d;
	assign hold_clear = (rd_hit && pending_interrupt_code == UIFC_CODE_HOLD_EMPTY)
		|| thr_written || !tx_empty_irq_enable;

	// ------------------------------------------------------------
	// priority and views
	// ------------------------------------------------------------
	uifc_prio u_prio (
		.line_pend(line_gated),
		.rx_pend(rx_gated),
		.tmo_pend(tmo_gated),
		.hold_pend(st_reg.holding_empty_event),
		.modem_pend(modem_gated),
		.code(pending_interrupt_code)
	);

	// upper status bits mirror the fifo enable
	assign fifos_enabled_status = st_reg.fifo_enable_bit ?
		UIFC_FIFOSTAT_ON : UIFC_FIFOSTAT_OFF;

	// reserved bits 4 and 5 are constant zero
	assign interrupt_ident_view = {fifos_enabled_status, 2'h0,
		pending_interrupt_code};

	// reads of any other address return zero
	assign rd_value = rd_hit ? interrupt_ident_view : 8'h00;

	// write-side view as held; reset bits are pulses
	assign fifo_control_view = {st_reg.rx_trigger_level, st_reg.tx_empty_threshold,
		st_reg.dma_mode_select, st_reg.tx_fifo_reset_bit, st_reg.rx_fifo_reset_bit,
		st_reg.fifo_enable_bit};

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		st_next = st_reg;

		// reset pulses last one cycle
		st_next.rx_fifo_reset_bit = 1'b0;
		st_next.tx_fifo_reset_bit = 1'b0;

		// control view changes only on writes
		if (wr_hit) begin
			st_next.fifo_enable_bit = wr_fifo_en;
			st_next.dma_mode_select = wdata[UIFC_DMA_MODE_POS];
			st_next.tx_empty_threshold = wdata[UIFC_TX_THR_LSB +: 2];
			st_next.rx_trigger_level = wdata[UIFC_RX_TRIG_LSB +: 2];
			if (wr_rx_rst) begin
				st_next.rx_fifo_reset_bit = 1'b1;
			end
			if (wr_tx_rst) begin
				st_next.tx_fifo_reset_bit = 1'b1;
			end
			if (wr_enable_flip) begin
				st_next.rx_fifo_reset_bit = 1'b1;
				st_next.tx_fifo_reset_bit = 1'b1;
			end
		end

		// read data; unmapped reads return zero
		if (rd_en) begin
			st_next.rdata = rd_value;
		end

		// holding empty event: reading it or a write to the holding
		// register clears it; a new rising condition wins over the clear
		st_next.hold_cond_d = hold_armed;
		if (hold_clear) begin
			st_next.holding_empty_event = 1'b0;
		end
		if (hold_rise) begin
			st_next.holding_empty_event = 1'b1;
		end

		// rts: flow control drops it at the trigger level
		if (rts_flow_stop) begin
			st_next.rts_n = 1'b1;
		end else begin
			st_next.rts_n = !rts_request;
		end

		// summary interrupt level
		st_next.intr = pending_interrupt_code != UIFC_CODE_NONE;
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------

	// reset leaves the view at no interrupt, fifos off
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg.fifo_enable_bit <= UIFC_CTRL1_RESET;
			st_reg.dma_mode_select <= UIFC_CTRL1_RESET;
			st_reg.tx_empty_threshold <= UIFC_CTRL2_RESET;
			st_reg.rx_trigger_level <= UIFC_CTRL2_RESET;
			st_reg.rx_fifo_reset_bit <= 1'b0;
			st_reg.tx_fifo_reset_bit <= 1'b0;
			st_reg.rdata <= UIFC_IDENT_RESET;
			st_reg.holding_empty_event <= 1'b0;
			st_reg.hold_cond_d <= 1'b0;
			st_reg.rts_n <= 1'b1;
			st_reg.intr <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	// ------------------------------------------------------------
	// dma request generator
	// ------------------------------------------------------------
	assign lv.rx_level = rx_level;
	assign lv.tx_level = tx_level;
	assign lv.rx_trig_lvl = rx_trig_lvl;
	assign lv.tx_thr_lvl = tx_thr_lvl;
	assign lv.fifo_en = st_reg.fifo_enable_bit;
	assign lv.dma_mode = st_reg.dma_mode_select;
	assign lv.rx_rst = st_next.rx_fifo_reset_bit;
	assign lv.tx_rst = st_next.tx_fifo_reset_bit;
	assign lv.rx_timeout = char_timeout;

	uifc_dma #(.DEPTH(DEPTH)) u_dma (
		.clk(clk),
		.rst_b(rst_b),
		.lv(lv.dma),
		.tx_req_n(dma_tx_req_n),
		.tx_single_n(dma_tx_single_n),
		.rx_req_n(dma_rx_req_n),
		.rx_single_n(dma_rx_single_n)
	);

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------

	// upper 24 bits of the word are always zero
	assign rdata = {24'h000000, st_reg.rdata};
	assign fifo_enable = st_reg.fifo_enable_bit;
	assign rx_fifo_reset = st_reg.rx_fifo_reset_bit;
	assign tx_fifo_reset = st_reg.tx_fifo_reset_bit;
	assign rts_n = st_reg.rts_n;
	assign intr = st_reg.intr;

endmodule

// *** verif/uart_int_id_fifo_control_test.sv ***
/*
 * self-checking bench: register reads and writes, fifo counts and sources.
 * assumes the fifo model and the checker bound to the block.
 */
`timescale 1ns/1ns
module uart_int_id_fifo_control_test;
	import uifc_pkg::*;
	localparam int DEPTH = 16;
	localparam int LW = 5;
	localparam logic [31:0] A = UIFC_INT_IDENT_FIFO_CTRL_ADDR;
	logic clk = 1'b0, rst_b = 1'b0, wr_en = 1'b0, rd_en = 1'b0, afce = 1'b0;
	logic rts_request = 1'b0, load = 1'b0, thr_written = 1'b0;
	logic line_status_pend = 1'b0, modem_status_pend = 1'b0, char_timeout = 1'b0;
	logic [31:0] addr = 32'h0, wdata = 32'h0, rdata;
	logic [7:0] int_enable = 8'h00;
	logic [LW-1:0] rx_new = '0, tx_new = '0, rx_level, tx_level;
	logic fifo_enable, rx_fifo_reset, tx_fifo_reset, rts_n, intr;
	logic dma_tx_req_n, dma_tx_single_n, dma_rx_req_n, dma_rx_single_n;
	int error_cnt = 0, n_checks = 0;
	int trig[4], thr[4];

	always #20 clk = ~clk;

	uifc_top #(.DEPTH(DEPTH)) uifc_top_inst (.clk, .rst_b, .addr, .wr_en, .rd_en, .wdata,
		.rdata, .int_enable, .afce, .rts_request, .line_status_pend, .modem_status_pend,
		.char_timeout, .thr_written, .rx_level, .tx_level, .fifo_enable, .rx_fifo_reset,
		.tx_fifo_reset, .rts_n, .intr, .dma_tx_req_n, .dma_tx_single_n, .dma_rx_req_n,
		.dma_rx_single_n);
	uifc_fifo_model #(.LW(LW)) uifc_fifo_model_inst (.clk, .rst_b, .rx_fifo_reset,
		.tx_fifo_reset, .load, .rx_new, .tx_new, .rx_level, .tx_level);

	// ------------------------------------------------------------
	// access and compare tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		@(negedge clk);
		wr_en = 1'b1;
		addr = a;
		wdata = {24'h0, d};
		@(negedge clk);
		wr_en = 1'b0;
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		@(negedge clk);
		rd_en = 1'b1;
		addr = a;
		@(negedge clk);
		rd_en = 1'b0;
		chk("rdata", rdata, exp);
	endtask
	// load fifo counts, then let the block settle
	task automatic lv(input int rx, input int tx);
		@(negedge clk);
		load = 1'b1;
		rx_new = LW'(rx);
		tx_new = LW'(tx);
		@(negedge clk);
		load = 1'b0;
		repeat (2) @(negedge clk);
	endtask
	task automatic print_verdict;
		if (error_cnt == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		print_verdict();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		trig = '{1, DEPTH / 4, DEPTH / 2, DEPTH - 2};
		thr = '{0, 2, DEPTH / 4, DEPTH / 2};
		repeat (16) @(negedge clk);
		rst_b = 1'b1;
		rd(A, 32'h01);
		rd(A + 32'h4, 32'h0);
		wr(A + 32'h4, 8'h01);
		chk("stray enable", {31'h0, fifo_enable}, 32'h0);
		wr(A, 8'h01);
		chk("enable resets", {29'h0, fifo_enable, rx_fifo_reset, tx_fifo_reset}, 32'h7);
		rd(A, 32'hc1);
		// source codes and their ranking
		int_enable = 8'h0d;
		modem_status_pend = 1'b1;
		rd(A, 32'hc0);
		char_timeout = 1'b1;
		rd(A, 32'hcc);
		lv(1, 0);
		rd(A, 32'hc4);
		line_status_pend = 1'b1;
		rd(A, 32'hc6);
		chk("intr", {31'h0, intr}, 32'h1);
		line_status_pend = 1'b0;
		modem_status_pend = 1'b0;
		char_timeout = 1'b0;
		int_enable = 8'h0c;
		rd(A, 32'hc1);
		chk("intr idle", {31'h0, intr}, 32'h0);
		// rx trigger levels and flow control
		int_enable = 8'h01;
		afce = 1'b1;
		rts_request = 1'b1;
		for (int k = 0; k < 4; k++) begin
			wr(A, 8'(k * 64 + 1));
			lv(trig[k] - 1, 1);
			rd(A, 32'hc1);
			chk("rts_n below", {31'h0, rts_n}, 32'h0);
			lv(trig[k], 1);
			rd(A, 32'hc4);
			chk("rts_n at trigger", {31'h0, rts_n}, 32'h1);
		end
		// tx empty thresholds, clear on read
		int_enable = 8'h82;
		afce = 1'b0;
		for (int k = 0; k < 4; k++) begin
			wr(A, 8'(k * 16 + 1));
			lv(0, thr[k] + 1);
			lv(0, thr[k]);
			rd(A, 32'hc2);
			rd(A, 32'hc1);
			chk("tx req mode 0", {31'h0, dma_tx_req_n}, {31'h0, thr[k] != 0});
		end
		int_enable = 8'h02;
		lv(0, 1);
		rd(A, 32'hc1);
		lv(0, 0);
		rd(A, 32'hc2);
		lv(0, 1);
		lv(0, 0);
		chk("intr hold", {31'h0, intr}, 32'h1);
		thr_written = 1'b1;
		@(negedge clk);
		thr_written = 1'b0;
		rd(A, 32'hc1);
		// multi-transfer dma requests
		int_enable = 8'h00;
		wr(A, 8'h59);
		lv(0, DEPTH);
		chk("tx req full", {30'h0, dma_tx_req_n, dma_tx_single_n}, 32'h3);
		lv(0, 3);
		chk("tx req held", {31'h0, dma_tx_req_n}, 32'h1);
		lv(0, 2);
		chk("tx req at thr", {31'h0, dma_tx_req_n}, 32'h0);
		lv(2, 2);
		chk("rx req below", {30'h0, dma_rx_req_n, dma_rx_single_n}, 32'h2);
		lv(4, 2);
		chk("rx req at trig", {31'h0, dma_rx_req_n}, 32'h0);
		// fifo resets and disable
		wr(A, 8'h5b);
		chk("rx reset", {29'h0, rx_fifo_reset, tx_fifo_reset, dma_rx_req_n & dma_rx_single_n}, 32'h5);
		wr(A, 8'h5d);
		chk("tx reset", {29'h0, tx_fifo_reset, rx_fifo_reset, dma_tx_req_n & dma_tx_single_n}, 32'h5);
		@(negedge clk);
		chk("self clear", {30'h0, rx_fifo_reset, tx_fifo_reset}, 32'h0);
		wr(A, 8'h58);
		chk("disable resets", {29'h0, fifo_enable, rx_fifo_reset, tx_fifo_reset}, 32'h3);
		rd(A, 32'h01);
		print_verdict();
	end
endmodule

// *** verif/uifc_fifo_model.sv ***
/*
 * neighbouring fifo pair: holds the rx and tx fill counts seen by the block.
 * assumes the bench loads new counts and the block's reset pulses empty them.
 */
`timescale 1ns/1ns
module uifc_fifo_model #(
	parameter int LW = 5
) (
	input wire logic clk, // system clock
	input wire logic rst_b, // async reset, active low
	input wire logic rx_fifo_reset, // rx control reset pulse
	input wire logic tx_fifo_reset, // tx control reset pulse
	input wire logic load, // take new counts
	input wire logic [LW-1:0] rx_new, // next rx count
	input wire logic [LW-1:0] tx_new, // next tx count
	output logic [LW-1:0] rx_level, // rx fill count
	output logic [LW-1:0] tx_level // tx fill count
);
	// counts follow the bench; a reset pulse treats that fifo as empty
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_level <= '0;
			tx_level <= '0;
		end else begin
			if (load) begin
				rx_level <= rx_new;
				tx_level <= tx_new;
			end
			if (rx_fifo_reset) begin
				rx_level <= '0;
			end
			if (tx_fifo_reset) begin
				tx_level <= '0;
			end
		end
	end
endmodule

// *** verif/uifc_top_properties.sv ***
/*
 * concurrent checks on the ports of the identification / fifo control block.
 * assumes one clock domain and the bind at the foot of this file.
 */
`timescale 1ns/1ns
module uifc_top_properties
	import uifc_pkg::*;
#(
	parameter int DEPTH = 16,
	parameter int LW = 5
) (
	input wire logic clk, // clock
	input wire logic rst_b, // reset, active low
	input wire logic [31:0] addr, // address
	input wire logic wr_en, // write strobe
	input wire logic rd_en, // read strobe
	input wire logic [31:0] wdata, // write data
	input wire logic [31:0] rdata, // read data
	input wire logic afce, // flow control on
	input wire logic rts_request, // software rts
	input wire logic fifo_enable, // fifos on
	input wire logic rx_fifo_reset, // rx reset pulse
	input wire logic tx_fifo_reset, // tx reset pulse
	input wire logic rts_n, // rts, active low
	input wire logic intr, // interrupt summary
	input wire logic dma_tx_req_n, // tx request
	input wire logic dma_tx_single_n, // tx single
	input wire logic dma_rx_req_n, // rx request
	input wire logic dma_rx_single_n // rx single
);
	// ------------------------------------------------------------
	// accesses that hit the shared location
	// ------------------------------------------------------------
	logic hit_wr;
	logic hit_rd;
	assign hit_wr = wr_en && addr == UIFC_INT_IDENT_FIFO_CTRL_ADDR;
	assign hit_rd = rd_en && addr == UIFC_INT_IDENT_FIFO_CTRL_ADDR;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_upper_zero: assert property (rdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	a_busy_never: assert property (rdata[3:0] != UIFC_CODE_BUSY)
		else $error("busy code reported");
	a_resv_zero: assert property (rdata[5:4] == 2'h0)
		else $error("reserved read bits set");
	a_fifo_status: assert property (hit_rd |=> rdata[7:6] == {2{$past(fifo_enable)}})
		else $error("fifo status bits wrong");
	a_code_summary: assert property (hit_rd |=> intr == (rdata[3:0] != UIFC_CODE_NONE))
		else $error("code and interrupt summary disagree");
	a_miss_read: assert property (rd_en && !hit_rd |=> rdata == 32'h0)
		else $error("unmapped read not zero");
	a_enable_flip: assert property (hit_wr && wdata[0] != fifo_enable |=>
		fifo_enable == $past(wdata[0]) && rx_fifo_reset && tx_fifo_reset)
		else $error("enable change without both resets");
	a_rx_reset: assert property (hit_wr && wdata[1] |=>
		rx_fifo_reset && dma_rx_req_n && dma_rx_single_n)
		else $error("rx reset write not honoured");
	a_tx_reset: assert property (hit_wr && wdata[2] |=>
		tx_fifo_reset && dma_tx_req_n && dma_tx_single_n)
		else $error("tx reset write not honoured");
	a_reset_selfclear: assert property (!hit_wr |=> !rx_fifo_reset && !tx_fifo_reset)
		else $error("fifo reset pulse without write");
	a_rts_manual: assert property (!afce |=> rts_n == !$past(rts_request))
		else $error("rts not following request");

	// ------------------------------------------------------------
	// covers
	// ------------------------------------------------------------
	c_rx_reset: cover property (hit_wr && wdata[1]);
	c_hold_read: cover property (hit_rd ##1 rdata[3:0] == UIFC_CODE_HOLD_EMPTY);
	c_flow_stop: cover property (afce && rts_request ##1 rts_n);
endmodule

bind uifc_top uifc_top_properties #(.DEPTH(DEPTH), .LW(LW)) uifc_top_properties_inst (
	.clk, .rst_b, .addr, .wr_en, .rd_en, .wdata, .rdata, .afce, .rts_request, .fifo_enable,
	.rx_fifo_reset, .tx_fifo_reset, .rts_n, .intr, .dma_tx_req_n, .dma_tx_single_n,
	.dma_rx_req_n, .dma_rx_single_n);
